//--- gxd_pkg.sv
// Shared constants and types for the guest exit decision block
package gxd_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL      = 5'h00;
  localparam logic [4:0] OFS_GAP       = 5'h04;
  localparam logic [4:0] OFS_WINDOW    = 5'h08;
  localparam logic [4:0] OFS_THRESH    = 5'h0C;
  localparam logic [4:0] OFS_PAGE      = 5'h10;
  localparam logic [4:0] OFS_STATUS    = 5'h14;
  localparam logic [4:0] OFS_EXITCNT   = 5'h18;
  localparam logic [4:0] OFS_TIME      = 5'h1C;

  // Control register field positions
  localparam int unsigned B_PAUSE_EXIT   = 0;
  localparam int unsigned B_LOOP_EXIT    = 1;
  localparam int unsigned B_USE_BITMAPS  = 2;
  localparam int unsigned B_PERF_EXIT    = 3;
  localparam int unsigned B_RAND_EXIT    = 4;
  localparam int unsigned B_TS_EXIT      = 5;
  localparam int unsigned B_TS_AUX_EN    = 6;
  localparam int unsigned B_FLUSH_EXIT   = 7;
  localparam int unsigned B_PRIO_LD_EXIT = 8;
  localparam int unsigned B_USE_SHADOW   = 9;
  localparam int unsigned B_EXT_VIRT     = 10;
  localparam int unsigned B_PAGE_VIRT    = 11;
  localparam int unsigned B_SECONDARY    = 31;

  // Secondary controls, forced to zero while the secondary enable is clear
  localparam logic [31:0] SECONDARY_MASK = 32'h0000_0CD2;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] GAP_RST    = 32'h0000_0080;
  localparam logic [31:0] WINDOW_RST = 32'h0000_1000;
  localparam logic [3:0]  THRESH_RST = 4'h0;
  localparam logic [19:0] PAGE_RST   = 20'hFEE00;

  // Index ranges of model-specific registers covered by bitmaps
  localparam logic [31:0] IDX_LOW_BASE  = 32'h0000_0000;
  localparam logic [31:0] IDX_HIGH_BASE = 32'hC000_0000;
  localparam logic [31:0] IDX_SPAN_MASK = 32'h0000_1FFF;
  localparam logic [31:0] IDX_PRIO      = 32'h0000_0808;

  // Priority field location inside the access page
  localparam logic [7:0]  PRIO_FIELD_LINE = 8'h08;

  // Bitmap selectors
  localparam logic [1:0] BM_READ_LOW   = 2'h0;
  localparam logic [1:0] BM_READ_HIGH  = 2'h1;
  localparam logic [1:0] BM_WRITE_LOW  = 2'h2;
  localparam logic [1:0] BM_WRITE_HIGH = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_PAUSE,
    OP_MODEL_READ,
    OP_MODEL_WRITE,
    OP_PERF_READ,
    OP_RANDOM_READ,
    OP_TS_READ,
    OP_TS_AUX_READ,
    OP_SYS_RESUME,
    OP_FLUSH,
    OP_PRIO_WRITE
  } gxd_op_type;

  typedef enum logic [3:0] {
    RSN_NONE,
    RSN_PAUSE,
    RSN_MODEL_READ,
    RSN_MODEL_WRITE,
    RSN_PERF_READ,
    RSN_RANDOM_READ,
    RSN_TS_READ,
    RSN_TS_AUX_READ,
    RSN_SYS_RESUME,
    RSN_FLUSH,
    RSN_PRIO_BELOW,
    RSN_PAGE_ACCESS
  } gxd_reason_type;

endpackage

//--- gxd_exit_decision.sv
// Guest exit decision logic with Avalon-MM control registers
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps

// What this block does
// - Privilege 0, both spin controls clear: spin hint runs without exit.
// - Spin-hint exiting set: exit at any privilege, loop control ignored.
// - First-in-loop when gap since last privilege-0 hint exceeds limit, or after entry.
// - Not first: exit when time since first-in-loop exceeds window limit.
// - Gap and window measured on a timestamp-rate counter.
// - Above privilege 0 loop control ignored; exit only if spin-hint exiting set.
// - Register read exits without bitmaps or with index outside both ranges.
// - Register read in range exits when its read bitmap bit is one.
// - Register write uses the same range rule with write bitmaps.
// - Counter read exits when its exiting control is one.
// - Random read exits when random exiting is one.
// - Timestamp read exits when timestamp exiting is one.
// - Timestamp-aux read exits only with timestamp exiting and aux enable.
// - Resume exits inside management mode, else invalid opcode.
// - Write-back flush exits when flush exiting is one.
// - Trap-like exits complete the instruction first; saved pointer is next.
// - Priority-control write lowering shadow below threshold traps, given controls.
// - Index 808H write lowering shadow below threshold traps, given controls.
// - Page-access virtualization: access on the access page exits.
// - Access-page decision uses the final physical address only.
// - Priority-shadow use exempts the priority field from page exits.
// - Higher-priority faults win over these exits.
module gxd_exit_decision (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Avalon-MM slave
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // Instruction from the pipeline
  input  wire logic                instr_valid,
  input  gxd_pkg::gxd_op_type      instr_op,
  input  wire logic [1:0]          current_privilege_level,
  input  wire logic                in_system_management_mode,
  input  wire logic                higher_fault,
  input  wire logic [31:0]         index_operand_reg,
  input  wire logic [3:0]          priority_new,
  input  wire logic                guest_entry,
  // Bitmap lookup
  output logic      [1:0]          bitmap_sel,
  output logic      [12:0]         bitmap_index,
  input  wire logic                bitmap_bit,
  // Memory access check
  input  wire logic                mem_valid,
  input  wire logic [31:0]         mem_phys_addr,
  input  wire logic                mem_fault,
  // Decision
  output logic                     exit_req,
  output logic                     exit_trap,
  output gxd_pkg::gxd_reason_type  exit_reason,
  output logic                     invalid_opcode,
  output logic                     page_exit
);

  typedef struct packed {
    logic [31:0]              ctrl;
    logic [31:0]              gap;
    logic [31:0]              window;
    logic [3:0]               thresh;
    logic [19:0]              page;
    logic [31:0]              now;
    logic [31:0]              last_pause;
    logic [31:0]              first_loop;
    logic                     seen;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     exit_req;
    logic                     exit_trap;
    gxd_pkg::gxd_reason_type  reason;
    logic                     inv_op;
    logic                     page_exit;
    logic [15:0]              exit_count;
  } gxd_state_type;

  gxd_state_type state_reg;
  gxd_state_type state_next;

  logic [31:0] ctrl_eff;
  logic        is_low;
  logic        is_high;
  logic        loop_active;
  logic        first_in_loop;
  logic        window_over;
  logic        fault_exit;
  logic        trap_exit;
  logic        in_page;
  logic        prio_field;

  function automatic logic [31:0] elapsed(input logic [31:0] now_t, input logic [31:0] then_t);
    elapsed = now_t - then_t;
  endfunction

  function automatic logic in_span(input logic [31:0] idx, input logic [31:0] base);
    in_span = (idx & ~gxd_pkg::IDX_SPAN_MASK) == base;
  endfunction

  assign ctrl_eff = state_reg.ctrl[gxd_pkg::B_SECONDARY] ? state_reg.ctrl
                    : (state_reg.ctrl & ~gxd_pkg::SECONDARY_MASK);

  // Bitmap lookup for register reads and writes
  assign is_low       = in_span(index_operand_reg, gxd_pkg::IDX_LOW_BASE);
  assign is_high      = in_span(index_operand_reg, gxd_pkg::IDX_HIGH_BASE);
  assign bitmap_index = index_operand_reg[12:0];
  assign bitmap_sel   = (instr_op == gxd_pkg::OP_MODEL_WRITE)
                        ? (is_high ? gxd_pkg::BM_WRITE_HIGH : gxd_pkg::BM_WRITE_LOW)
                        : (is_high ? gxd_pkg::BM_READ_HIGH : gxd_pkg::BM_READ_LOW);

  // Spin-loop timing on the free-running counter
  assign loop_active   = (current_privilege_level == 2'h0) && !ctrl_eff[gxd_pkg::B_PAUSE_EXIT]
                         && ctrl_eff[gxd_pkg::B_LOOP_EXIT];
  assign first_in_loop = !state_reg.seen
                         || (elapsed(state_reg.now, state_reg.last_pause) > state_reg.gap);
  assign window_over   = elapsed(state_reg.now, state_reg.first_loop) > state_reg.window;

  // Physical page match; callers hand in the final physical address
  assign in_page    = mem_phys_addr[31:12] == state_reg.page;
  assign prio_field = mem_phys_addr[11:4] == gxd_pkg::PRIO_FIELD_LINE;

  always_comb
  begin
    fault_exit = 1'b0;
    trap_exit  = 1'b0;
    case (instr_op)
      gxd_pkg::OP_PAUSE:
        fault_exit = ctrl_eff[gxd_pkg::B_PAUSE_EXIT]
                     || (loop_active && !first_in_loop && window_over);
      gxd_pkg::OP_MODEL_READ,
      gxd_pkg::OP_MODEL_WRITE:
      begin
        fault_exit = !ctrl_eff[gxd_pkg::B_USE_BITMAPS] || !(is_low || is_high) || bitmap_bit;
        trap_exit  = (instr_op == gxd_pkg::OP_MODEL_WRITE) && (index_operand_reg == gxd_pkg::IDX_PRIO)
                     && ctrl_eff[gxd_pkg::B_EXT_VIRT] && (priority_new < state_reg.thresh);
      end
      gxd_pkg::OP_PERF_READ:   fault_exit = ctrl_eff[gxd_pkg::B_PERF_EXIT];
      gxd_pkg::OP_RANDOM_READ: fault_exit = ctrl_eff[gxd_pkg::B_RAND_EXIT];
      gxd_pkg::OP_TS_READ:     fault_exit = ctrl_eff[gxd_pkg::B_TS_EXIT];
      gxd_pkg::OP_TS_AUX_READ:
        fault_exit = ctrl_eff[gxd_pkg::B_TS_EXIT] && ctrl_eff[gxd_pkg::B_TS_AUX_EN];
      gxd_pkg::OP_SYS_RESUME:  fault_exit = in_system_management_mode;
      gxd_pkg::OP_FLUSH:       fault_exit = ctrl_eff[gxd_pkg::B_FLUSH_EXIT];
      gxd_pkg::OP_PRIO_WRITE:
        trap_exit = !ctrl_eff[gxd_pkg::B_PRIO_LD_EXIT] && ctrl_eff[gxd_pkg::B_USE_SHADOW]
                    && (priority_new < state_reg.thresh);
      default:
      begin
        fault_exit = 1'b0;
        trap_exit  = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    state_next           = state_reg;
    state_next.now       = state_reg.now + 32'h0000_0001;
    state_next.exit_req  = 1'b0;
    state_next.exit_trap = 1'b0;
    state_next.reason    = gxd_pkg::RSN_NONE;
    state_next.inv_op    = 1'b0;
    state_next.page_exit = 1'b0;

    // Bus slave: one wait cycle, then answer
    state_next.ack = (read || write) && !state_reg.ack;
    if ((read || write) && !state_reg.ack)
    begin
      case (address)
        gxd_pkg::OFS_CTRL:    state_next.rdata = state_reg.ctrl;
        gxd_pkg::OFS_GAP:     state_next.rdata = state_reg.gap;
        gxd_pkg::OFS_WINDOW:  state_next.rdata = state_reg.window;
        gxd_pkg::OFS_THRESH:  state_next.rdata = {28'h0000000, state_reg.thresh};
        gxd_pkg::OFS_PAGE:    state_next.rdata = {state_reg.page, 12'h000};
        gxd_pkg::OFS_STATUS:  state_next.rdata = {23'h000000, state_reg.seen, state_reg.reason,
                                                  state_reg.page_exit, state_reg.inv_op,
                                                  state_reg.exit_trap, state_reg.exit_req};
        gxd_pkg::OFS_EXITCNT: state_next.rdata = {16'h0000, state_reg.exit_count};
        gxd_pkg::OFS_TIME:    state_next.rdata = state_reg.now;
        default:              state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (write && state_reg.ack)
    begin
      case (address)
        gxd_pkg::OFS_CTRL:   state_next.ctrl   = writedata;
        gxd_pkg::OFS_GAP:    state_next.gap    = writedata;
        gxd_pkg::OFS_WINDOW: state_next.window = writedata;
        gxd_pkg::OFS_THRESH: state_next.thresh = writedata[3:0];
        gxd_pkg::OFS_PAGE:   state_next.page   = writedata[31:12];
        default:             state_next.seen   = state_reg.seen;
      endcase
    end

    // Instruction decision; higher faults suppress every instruction exit
    if (instr_valid && !higher_fault)
    begin
      if (instr_op == gxd_pkg::OP_PAUSE && loop_active)
      begin
        state_next.last_pause = state_reg.now;
        state_next.seen       = 1'b1;
        if (first_in_loop)
          state_next.first_loop = state_reg.now;
      end
      if (fault_exit || trap_exit)
      begin
        state_next.exit_req   = 1'b1;
        state_next.exit_trap  = !fault_exit && trap_exit;
        state_next.exit_count = state_reg.exit_count + 16'h0001;
        case (instr_op)
          gxd_pkg::OP_PAUSE:       state_next.reason = gxd_pkg::RSN_PAUSE;
          gxd_pkg::OP_MODEL_READ:  state_next.reason = gxd_pkg::RSN_MODEL_READ;
          gxd_pkg::OP_MODEL_WRITE:
            state_next.reason = fault_exit ? gxd_pkg::RSN_MODEL_WRITE : gxd_pkg::RSN_PRIO_BELOW;
          gxd_pkg::OP_PERF_READ:   state_next.reason = gxd_pkg::RSN_PERF_READ;
          gxd_pkg::OP_RANDOM_READ: state_next.reason = gxd_pkg::RSN_RANDOM_READ;
          gxd_pkg::OP_TS_READ:     state_next.reason = gxd_pkg::RSN_TS_READ;
          gxd_pkg::OP_TS_AUX_READ: state_next.reason = gxd_pkg::RSN_TS_AUX_READ;
          gxd_pkg::OP_SYS_RESUME:  state_next.reason = gxd_pkg::RSN_SYS_RESUME;
          gxd_pkg::OP_FLUSH:       state_next.reason = gxd_pkg::RSN_FLUSH;
          gxd_pkg::OP_PRIO_WRITE:  state_next.reason = gxd_pkg::RSN_PRIO_BELOW;
          default:                 state_next.reason = gxd_pkg::RSN_NONE;
        endcase
      end
      else if (instr_op == gxd_pkg::OP_SYS_RESUME)
        state_next.inv_op = 1'b1;
    end

    // Access-page check on physical addresses
    if (mem_valid && !mem_fault && ctrl_eff[gxd_pkg::B_PAGE_VIRT] && in_page
        && !(ctrl_eff[gxd_pkg::B_USE_SHADOW] && prio_field))
    begin
      state_next.page_exit = 1'b1;
      if (!state_next.exit_req)
        state_next.reason = gxd_pkg::RSN_PAGE_ACCESS;
    end

    // Entry restarts loop tracking
    if (guest_entry)
    begin
      state_next.seen       = 1'b0;
      state_next.last_pause = state_reg.now;
      state_next.first_loop = state_reg.now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg            <= '0;
      state_reg.ctrl       <= gxd_pkg::CTRL_RST;
      state_reg.gap        <= gxd_pkg::GAP_RST;
      state_reg.window     <= gxd_pkg::WINDOW_RST;
      state_reg.thresh     <= gxd_pkg::THRESH_RST;
      state_reg.page       <= gxd_pkg::PAGE_RST;
      state_reg.reason     <= gxd_pkg::RSN_NONE;
    end
    else
      state_reg <= state_next;
  end

  assign readdata       = state_reg.rdata;
  assign waitrequest    = (read || write) && !state_reg.ack;
  assign exit_req       = state_reg.exit_req;
  assign exit_trap      = state_reg.exit_trap;
  assign exit_reason    = state_reg.reason;
  assign invalid_opcode = state_reg.inv_op;
  assign page_exit      = state_reg.page_exit;

  // Checks
  chk_pause_plain_run: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && instr_op == gxd_pkg::OP_PAUSE && current_privilege_level == 2'h0
     && !ctrl_eff[gxd_pkg::B_PAUSE_EXIT] && !ctrl_eff[gxd_pkg::B_LOOP_EXIT]) |=> !exit_req)
    else $error("spin hint exited with both controls clear");

  chk_pause_exit_any: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_PAUSE && ctrl_eff[gxd_pkg::B_PAUSE_EXIT])
    |=> exit_req && !exit_trap && exit_reason == gxd_pkg::RSN_PAUSE)
    else $error("spin hint did not exit with exiting set");

  chk_pause_upper_priv: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && instr_op == gxd_pkg::OP_PAUSE && current_privilege_level != 2'h0
     && !ctrl_eff[gxd_pkg::B_PAUSE_EXIT]) |=> !exit_req)
    else $error("loop exiting applied above privilege 0");

  chk_loop_window_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_PAUSE && loop_active
     && !first_in_loop && window_over) |=> exit_req && exit_reason == gxd_pkg::RSN_PAUSE)
    else $error("window overrun did not exit");

  chk_entry_restart: assert property (@(posedge clk_sys) disable iff (rst)
    guest_entry |=> !state_reg.seen && state_reg.first_loop == $past(state_reg.now))
    else $error("entry did not restart loop tracking");

  chk_bitmap_off_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_MODEL_READ
     && !ctrl_eff[gxd_pkg::B_USE_BITMAPS]) |=> exit_req && !exit_trap)
    else $error("register read without bitmaps did not exit");

  chk_aux_needs_both: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && instr_op == gxd_pkg::OP_TS_AUX_READ
     && !(ctrl_eff[gxd_pkg::B_TS_EXIT] && ctrl_eff[gxd_pkg::B_TS_AUX_EN])) |=> !exit_req)
    else $error("aux timestamp read exited without both controls");

  chk_resume_outside: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_SYS_RESUME && !in_system_management_mode)
    |=> invalid_opcode && !exit_req)
    else $error("resume outside management mode not invalid");

  chk_secondary_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && instr_op == gxd_pkg::OP_FLUSH && !state_reg.ctrl[gxd_pkg::B_SECONDARY]) |=> !exit_req)
    else $error("secondary control acted while gated");

  chk_prio_trap: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_PRIO_WRITE
     && !ctrl_eff[gxd_pkg::B_PRIO_LD_EXIT] && ctrl_eff[gxd_pkg::B_USE_SHADOW]
     && priority_new < state_reg.thresh) |=> exit_req && exit_trap)
    else $error("priority drop did not trap");

  chk_fault_wins: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && higher_fault) |=> !exit_req && !invalid_opcode)
    else $error("exit raised over a higher fault");

  chk_prio_field_exempt: assert property (@(posedge clk_sys) disable iff (rst)
    (mem_valid && prio_field && ctrl_eff[gxd_pkg::B_USE_SHADOW]) |=> !page_exit)
    else $error("priority field access raised page exit");

  chk_bus_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest || !(read || write))
    else $error("bus answer not after exactly one wait");

  chk_read_bitmap_hit: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_MODEL_READ && bitmap_bit) |=> exit_req)
    else $error("register read with bitmap bit set did not exit");

  chk_write_bitmap_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && instr_op == gxd_pkg::OP_MODEL_WRITE && ctrl_eff[gxd_pkg::B_USE_BITMAPS] && is_low
     && !bitmap_bit && index_operand_reg != gxd_pkg::IDX_PRIO) |=> !exit_req)
    else $error("register write exited with bitmap bit clear");

  chk_random_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_RANDOM_READ && ctrl_eff[gxd_pkg::B_RAND_EXIT])
    |=> exit_req)
    else $error("random read did not exit");

  chk_index_prio_trap: assert property (@(posedge clk_sys) disable iff (rst)
    (instr_valid && !higher_fault && instr_op == gxd_pkg::OP_MODEL_WRITE && ctrl_eff[gxd_pkg::B_USE_BITMAPS]
     && index_operand_reg == gxd_pkg::IDX_PRIO && !bitmap_bit && ctrl_eff[gxd_pkg::B_EXT_VIRT]
     && priority_new < state_reg.thresh) |=> exit_req && exit_trap)
    else $error("index priority write did not trap");

  chk_page_access_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (mem_valid && !mem_fault && ctrl_eff[gxd_pkg::B_PAGE_VIRT] && in_page && !prio_field) |=> page_exit)
    else $error("access page hit did not exit");

  cov_loop_exit: cover property (@(posedge clk_sys) disable iff (rst)
    exit_req && exit_reason == gxd_pkg::RSN_PAUSE && !ctrl_eff[gxd_pkg::B_PAUSE_EXIT]);
  cov_trap_exit: cover property (@(posedge clk_sys) disable iff (rst) exit_req && exit_trap);
  cov_page_exit: cover property (@(posedge clk_sys) disable iff (rst) page_exit);
  cov_bitmap_exit: cover property (@(posedge clk_sys) disable iff (rst)
    exit_req && exit_reason == gxd_pkg::RSN_MODEL_WRITE);

endmodule // gxd_exit_decision

//--- gxd_pipe_model.sv
// Pipeline-side bitmap store answering each lookup in the same cycle
`timescale 1ns/10ps
module gxd_pipe_model (
  // Lookup from the decision block
  input  wire logic [1:0]  bitmap_sel,
  input  wire logic [12:0] bitmap_index,
  output logic             bitmap_bit
);
  logic bits [4][8192] = '{default: 1'b0};
  assign bitmap_bit = bits[bitmap_sel][bitmap_index];
endmodule // gxd_pipe_model

//--- tb_top.sv
// Self-checking bench for the guest exit decision block
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, instr_valid = 1'b0, mgmt = 1'b0;
  logic higher_fault = 1'b0, guest_entry = 1'b0, mem_valid = 1'b0, mem_fault = 1'b0;
  logic waitrequest, bitmap_bit, exit_req, exit_trap, invalid_opcode, page_exit;
  logic [1:0]              priv = 2'h0, bitmap_sel;
  logic [3:0]              prio = 4'h0;
  logic [4:0]              address = 5'h00;
  logic [12:0]             bitmap_index;
  logic [31:0]             writedata = 32'h0, index_reg = 32'h0, mem_addr = 32'h0, readdata, rd;
  gxd_pkg::gxd_op_type     op = gxd_pkg::OP_NONE;
  gxd_pkg::gxd_reason_type exit_reason;
  int                      fail_count = 0, total_checks = 0, cyc = 0;

  gxd_exit_decision u_dut (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .instr_valid(instr_valid), .instr_op(op),
    .current_privilege_level(priv), .in_system_management_mode(mgmt), .higher_fault(higher_fault),
    .index_operand_reg(index_reg), .priority_new(prio), .guest_entry(guest_entry), .bitmap_sel(bitmap_sel),
    .bitmap_index(bitmap_index), .bitmap_bit(bitmap_bit), .mem_valid(mem_valid), .mem_phys_addr(mem_addr),
    .mem_fault(mem_fault), .exit_req(exit_req), .exit_trap(exit_trap), .exit_reason(exit_reason),
    .invalid_opcode(invalid_opcode), .page_exit(page_exit));
  gxd_pipe_model u_pipe (.bitmap_sel(bitmap_sel), .bitmap_index(bitmap_index), .bitmap_bit(bitmap_bit));

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do
      @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Expected reason: trap means priority drop, otherwise the instruction itself
  task instr(input gxd_pkg::gxd_op_type o, input logic [1:0] p, input logic [31:0] i, input logic [3:0] n,
             input logic h, input logic [2:0] e);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    op <= o;
    priv <= p;
    index_reg <= i;
    prio <= n;
    higher_fault <= h;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    higher_fault <= 1'b0;
    #1;
    chk({29'h0, exit_req, exit_trap, invalid_opcode}, {29'h0, e});
    if (e[2])
      chk({28'h0, exit_reason}, {28'h0, e[1] ? gxd_pkg::RSN_PRIO_BELOW : gxd_pkg::gxd_reason_type'(o)});
  endtask

  task mem(input logic [31:0] a, input logic f, input logic e);
    @(posedge clk_sys);
    mem_valid <= 1'b1;
    mem_addr <= a;
    mem_fault <= f;
    @(posedge clk_sys);
    mem_valid <= 1'b0;
    #1;
    chk({31'h0, page_exit}, {31'h0, e});
  endtask

  task t_regs();
    bus(1'b0, gxd_pkg::OFS_GAP, 32'h0);
    chk(rd, gxd_pkg::GAP_RST);
    bus(1'b0, gxd_pkg::OFS_PAGE, 32'h0);
    chk(rd, {gxd_pkg::PAGE_RST, 12'h000});
    bus(1'b1, 5'h1E, 32'hFFFF_FFFF);
    bus(1'b0, gxd_pkg::OFS_CTRL, 32'h0);
    chk(rd, gxd_pkg::CTRL_RST);
  endtask

  task t_simple();
    gxd_pkg::gxd_op_type ops [5];
    logic [4:0] m;
    ops = '{gxd_pkg::OP_PERF_READ, gxd_pkg::OP_RANDOM_READ, gxd_pkg::OP_TS_READ, gxd_pkg::OP_TS_AUX_READ,
            gxd_pkg::OP_FLUSH};
    m = 5'h05;
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, gxd_pkg::OFS_CTRL, {s[0], 23'h0, 8'hF8});
      for (int k = 0; k < 5; k++)
        instr(ops[k], 2'h3, 32'h0, 4'h0, 1'b0, {s[0] | m[k], 2'h0});
    end
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0040);
    instr(ops[3], 2'h0, 32'h0, 4'h0, 1'b0, 3'h0);
    instr(ops[2], 2'h0, 32'h0, 4'h0, 1'b1, 3'h0);
    instr(gxd_pkg::OP_SYS_RESUME, 2'h0, 32'h0, 4'h0, 1'b1, 3'h0);
    instr(gxd_pkg::OP_SYS_RESUME, 2'h0, 32'h0, 4'h0, 1'b0, 3'h1);
    @(posedge clk_sys);
    mgmt <= 1'b1;
    instr(gxd_pkg::OP_SYS_RESUME, 2'h0, 32'h0, 4'h0, 1'b0, 3'h4);
  endtask

  task t_bitmap();
    gxd_pkg::gxd_op_type r, w;
    r = gxd_pkg::OP_MODEL_READ;
    w = gxd_pkg::OP_MODEL_WRITE;
    instr(r, 2'h0, 32'h5, 4'h0, 1'b0, 3'h4);
    instr(w, 2'h0, 32'h5, 4'h0, 1'b0, 3'h4);
    u_pipe.bits[0][5] = 1'b1;
    u_pipe.bits[1][7] = 1'b1;
    u_pipe.bits[3][9] = 1'b1;
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h0000_0004);
    instr(r, 2'h0, 32'h0000_0005, 4'h0, 1'b0, 3'h4);
    instr(r, 2'h0, 32'h0000_0006, 4'h0, 1'b0, 3'h0);
    instr(r, 2'h0, 32'hC000_0007, 4'h0, 1'b0, 3'h4);
    instr(r, 2'h0, 32'h0000_2000, 4'h0, 1'b0, 3'h4);
    instr(r, 2'h0, 32'hC000_2000, 4'h0, 1'b0, 3'h4);
    instr(w, 2'h0, 32'hC000_0007, 4'h0, 1'b0, 3'h0);
    instr(w, 2'h0, 32'hC000_0009, 4'h0, 1'b0, 3'h4);
    bus(1'b1, gxd_pkg::OFS_THRESH, 32'h5);
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0604);
    instr(gxd_pkg::OP_PRIO_WRITE, 2'h0, 32'h0, 4'h4, 1'b0, 3'h6);
    instr(gxd_pkg::OP_PRIO_WRITE, 2'h0, 32'h0, 4'h5, 1'b0, 3'h0);
    instr(w, 2'h0, 32'h808, 4'h4, 1'b0, 3'h6);
    u_pipe.bits[2][13'h808] = 1'b1;
    instr(w, 2'h0, 32'h808, 4'h4, 1'b0, 3'h4);
  endtask

  task t_loop();
    int t, first, last;
    logic ex;
    last = -1000;
    first = 0;
    bus(1'b1, gxd_pkg::OFS_GAP, 32'h14);
    bus(1'b1, gxd_pkg::OFS_WINDOW, 32'h3C);
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0002);
    #1;
    for (int k = 0; k < 75; k++)
    begin
      if (k == 32)
        instr(gxd_pkg::OP_PAUSE, 2'h1, 32'h0, 4'h0, 1'b0, 3'h0);
      if (k == 34)
      begin
        @(posedge clk_sys);
        guest_entry <= 1'b1;
        @(posedge clk_sys);
        guest_entry <= 1'b0;
        #1;
        last = -1000;
      end
      if (k == 70)
      begin
        repeat (25) @(posedge clk_sys);
        #1;
      end
      t = cyc;
      ex = (t - last <= 20) && (t - first > 60);
      if (t - last > 20)
        first = t;
      last = t;
      instr(gxd_pkg::OP_PAUSE, 2'h0, 32'h0, 4'h0, 1'b0, {ex, 2'h0});
    end
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h0);
    instr(gxd_pkg::OP_PAUSE, 2'h0, 32'h0, 4'h0, 1'b0, 3'h0);
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0003);
    instr(gxd_pkg::OP_PAUSE, 2'h0, 32'h0, 4'h0, 1'b0, 3'h4);
    instr(gxd_pkg::OP_PAUSE, 2'h3, 32'h0, 4'h0, 1'b0, 3'h4);
  endtask

  task t_page();
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h0000_0800);
    mem(32'hFEE0_0010, 1'b0, 1'b0);
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0800);
    mem(32'hFEE0_0010, 1'b0, 1'b1);
    mem(32'hFEE0_1000, 1'b0, 1'b0);
    mem(32'hFEE0_0084, 1'b0, 1'b1);
    mem(32'hFEE0_0010, 1'b1, 1'b0);
    bus(1'b1, gxd_pkg::OFS_CTRL, 32'h8000_0A00);
    mem(32'hFEE0_0084, 1'b0, 1'b0);
    mem(32'hFEE0_0090, 1'b0, 1'b1);
    bus(1'b1, gxd_pkg::OFS_PAGE, 32'h1234_5000);
    mem(32'h1234_5FFC, 1'b0, 1'b1);
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_simple();
    t_bitmap();
    t_loop();
    t_page();
    finish_test();
  end
endmodule // tb_top
